// *** pllcg_defines.svh ***
/*
 loop clock generator control: register offsets, bit positions, reset values.
 assumes inclusion by the top module only.
*/
`ifndef PLLCG_DEFINES_SVH
`define PLLCG_DEFINES_SVH
`define PLLCG_OFF_CTRL 4'h0
`define PLLCG_OFF_BW 4'h4
`define PLLCG_OFF_PROG 4'h8
`define PLLCG_OFF_STAT 4'hc
`define PLLCG_CTRL_IE 7
`define PLLCG_CTRL_FLAG 6
`define PLLCG_CTRL_ON 5
`define PLLCG_CTRL_BCS 4
`define PLLCG_CTRL_UNUSED 4'hf
`define PLLCG_BW_AUTO 7
`define PLLCG_BW_LOCK 6
`define PLLCG_BW_ACQN 5
`define PLLCG_BW_XLD 4
`define PLLCG_PROG_RST 8'h66
`define PLLCG_SW_XCYC 2'h3
`define PLLCG_SW_VCYC 2'h3
`define PLLCG_RESP_OKAY 2'h0
`define PLLCG_RESP_SLVERR 2'h2
`endif

// *** pllcg_pkg.sv ***
/*
 types for the loop clock generator control block.
 assumes pllcg_defines.svh sits in the include path.
*/
package pllcg_pkg;
   typedef struct packed {
      logic [3:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [3:0] araddr;
      logic arvalid;
      logic rready;
   } pllcg_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } pllcg_axi_rsp_t;
   typedef enum logic [1:0] {
      PLLCG_SW_IDLE = 2'b00,
      PLLCG_SW_XTAL = 2'b01,
      PLLCG_SW_VCO = 2'b10
   } pllcg_sw_t;
endpackage

// *** pllcg_top.sv ***
/*
 loop clock generator control: three control registers over AXI4-Lite, lock
 flag and level interrupt, source-switch sequencing with held base clock.
 assumes the analog loop supplies lock, acquisition and crystal-loss status,
 and one-cycle edge pulses of the crystal and VCO clocks sampled on clk.
*/
// Functional notes
// RL1: irq enable writable and readable only in automatic mode; reset clears it.
// RL2: flag sets on every lock change in automatic mode; irq while flag and enable are high.
// RL3: manual mode reads flag as zero and gives no interrupt.
// RL4: any read of control register clears flag; reset clears it too.
// RL5: power-on starts loop; cannot clear while VCO selected; reset sets it.
// RL6: source select picks VCO or crystal; cannot set while loop off.
// RL7: switch waits three crystal cycles, then up to three VCO cycles, output held.
// RL8: reset and stop both clear source select.
// RL9: software powers loop first, then selects VCO in a second write.
// RL10: four low control bits unused, always read one.
// RL11: automatic mode bit; reset clears it; manual users clear acquire first.
// RL12: lock indicator read-only in auto, reads zero in manual, reset clears.
// RL13: capture bit: one tracking, zero acquisition; status in auto, control manual.
// RL14: manual capture value kept during automatic mode and restored afterwards.
// RL15: writing one to loss detect starts a check; software reads result later.
// RL16: loss detect works only with VCO selected, else reads zero.
// RL17: software writes zeros to the bandwidth register test bits.
// RL18: multiplier zero acts as one; reset loads six.
// RL19: multiplier and range fields locked while loop powered.
// RL20: range zero disables loop, clears and blocks VCO select; reset six.
// RL21: VCO may be selected before lock; software should check lock first.
// RL22: block stays active in wait mode; software may turn things off.
// RL23: multiplier in upper nibble, range in lower nibble of programming register.
// RL24: interrupt is flag AND enable, registered on the bus clock.
`timescale 1ns/10ps
`include "pllcg_defines.svh"
module pllcg_top (
   input wire logic clk,
   input wire logic rst,
   input wire pllcg_pkg::pllcg_axi_req_t axi_req,
   output pllcg_pkg::pllcg_axi_rsp_t axi_rsp,
   input wire logic stop_req,
   input wire logic lock_in,
   input wire logic tracking_in,
   input wire logic xtal_lost_in,
   input wire logic xtal_edge,
   input wire logic vco_edge,
   output logic loop_enable,
   output logic vco_selected,
   output logic base_clock_hold,
   output logic [3:0] feedback_div,
   output logic [3:0] range_mult,
   output logic manual_capture_phase_n,
   output logic loss_check_start,
   output logic loop_irq
);
   import pllcg_pkg::*;

   logic ie_r, ie_nxt, flag_r, flag_nxt, on_r, on_nxt, bcs_r, bcs_nxt;
   logic auto_r, auto_nxt, acq_r, acq_nxt, lock_r, lock_nxt;
   logic [3:0] bwtest_r, bwtest_nxt;
   logic [7:0] prog_r, prog_nxt;
   logic lock_q_r, lock_q_nxt, chk_r, chk_nxt, irq_r, irq_nxt;
   pllcg_sw_t sw_r, sw_nxt;
   logic [1:0] xcnt_r, xcnt_nxt, vcnt_r, vcnt_nxt;
   logic sel_r, sel_nxt, hold_r, hold_nxt;
   logic awh_r, awh_nxt, wh_r, wh_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [3:0] awa_r, awa_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic wen_r, wen_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic do_wr, do_rd, rd_ctrl;
   logic [7:0] ctrl_view, bw_view;
   logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, ardy_r, ardy_nxt, en_r, en_nxt;
   logic [3:0] fb_r, fb_nxt;

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == `PLLCG_OFF_CTRL) || (a == `PLLCG_OFF_BW) || (a == `PLLCG_OFF_PROG);
   endfunction

   // zero multiplier drives the divider as one
   function automatic logic [3:0] eff_mult(input logic [7:0] p);
      eff_mult = (p[7:4] == 4'h0) ? 4'h1 : p[7:4];
   endfunction

   // register read images
   always_comb begin
      ctrl_view = {4'h0, `PLLCG_CTRL_UNUSED}; // see RL10
      ctrl_view[`PLLCG_CTRL_IE] = ie_r & auto_r; // see RL1
      ctrl_view[`PLLCG_CTRL_FLAG] = flag_r & auto_r; // see RL3
      ctrl_view[`PLLCG_CTRL_ON] = on_r;
      ctrl_view[`PLLCG_CTRL_BCS] = bcs_r;
      bw_view = {4'h0, bwtest_r};
      bw_view[`PLLCG_BW_AUTO] = auto_r;
      bw_view[`PLLCG_BW_LOCK] = auto_r & lock_r; // see RL12
      bw_view[`PLLCG_BW_ACQN] = auto_r ? tracking_in : acq_r; // see RL13
      bw_view[`PLLCG_BW_XLD] = bcs_r & chk_r & xtal_lost_in; // see RL16
   end

   // bus slave: address and data latched in either order, then one response
   always_comb begin
      awh_nxt = awh_r;
      wh_nxt = wh_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      wen_nxt = wen_r;
      bv_nxt = bv_r;
      bresp_nxt = bresp_r;
      rv_nxt = rv_r;
      rd_nxt = rd_r;
      rresp_nxt = rresp_r;
      if (axi_req.awvalid && !awh_r && !bv_r) begin
         awh_nxt = 1'b1;
         awa_nxt = axi_req.awaddr;
      end
      if (axi_req.wvalid && !wh_r && !bv_r) begin
         wh_nxt = 1'b1;
         wd_nxt = axi_req.wdata[7:0];
         wen_nxt = axi_req.wstrb[0];
      end
      do_wr = awh_r && wh_r && !bv_r;
      if (do_wr) begin
         awh_nxt = 1'b0;
         wh_nxt = 1'b0;
         bv_nxt = 1'b1;
         bresp_nxt = mapped(awa_r) ? `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
      end else if (bv_r && axi_req.bready) begin
         bv_nxt = 1'b0;
      end
      do_rd = axi_req.arvalid && !rv_r;
      rd_ctrl = do_rd && (axi_req.araddr == `PLLCG_OFF_CTRL);
      if (do_rd) begin
         rv_nxt = 1'b1;
         rresp_nxt = `PLLCG_RESP_OKAY;
         case (axi_req.araddr)
            `PLLCG_OFF_CTRL: rd_nxt = ctrl_view;
            `PLLCG_OFF_BW: rd_nxt = bw_view;
            `PLLCG_OFF_PROG: rd_nxt = prog_r;
            `PLLCG_OFF_STAT: rd_nxt = {6'h00, hold_r, sel_r};
            default: begin
               rd_nxt = 8'h00;
               rresp_nxt = `PLLCG_RESP_SLVERR;
            end
         endcase
      end else if (rv_r && axi_req.rready) begin
         rv_nxt = 1'b0;
      end
      // readies kept in flops so every port leaves a register
      awrdy_nxt = !awh_nxt && !bv_nxt;
      wrdy_nxt = !wh_nxt && !bv_nxt;
      ardy_nxt = !rv_nxt;
   end

   // control state
   always_comb begin
      ie_nxt = ie_r;
      on_nxt = on_r;
      bcs_nxt = bcs_r;
      auto_nxt = auto_r;
      acq_nxt = acq_r;
      bwtest_nxt = bwtest_r;
      prog_nxt = prog_r;
      chk_nxt = 1'b0;
      lock_nxt = auto_r & lock_in; // see RL12
      lock_q_nxt = lock_r;
      flag_nxt = flag_r;
      if (rd_ctrl)
         flag_nxt = 1'b0; // see RL4
      if (auto_r && (lock_r != lock_q_r))
         flag_nxt = 1'b1; // set beats read clear, see RL2
      if (do_wr && wen_r) begin
         case (awa_r)
            `PLLCG_OFF_CTRL: begin
               if (auto_r)
                  ie_nxt = wd_r[`PLLCG_CTRL_IE]; // see RL1
               if (wd_r[`PLLCG_CTRL_ON] || !bcs_r)
                  on_nxt = wd_r[`PLLCG_CTRL_ON]; // see RL5
               // set only if power was on and stays on in this write, so
               // source and power never change together
               if (!wd_r[`PLLCG_CTRL_BCS] ||
                  (on_r && wd_r[`PLLCG_CTRL_ON] && prog_r[3:0] != 4'h0))
                  bcs_nxt = wd_r[`PLLCG_CTRL_BCS]; // see RL6 RL20 RL21
            end
            `PLLCG_OFF_BW: begin
               auto_nxt = wd_r[`PLLCG_BW_AUTO]; // see RL11
               if (!auto_r)
                  acq_nxt = wd_r[`PLLCG_BW_ACQN]; // see RL13
               bwtest_nxt = wd_r[3:0]; // see RL17
               chk_nxt = wd_r[`PLLCG_BW_XLD] & bcs_r; // see RL15
            end
            `PLLCG_OFF_PROG: begin
               if (!on_r)
                  prog_nxt = wd_r; // see RL19 RL23
            end
            default: begin
            end
         endcase
      end
      if (chk_r)
         chk_nxt = 1'b1;
      if (!bcs_nxt)
         chk_nxt = 1'b0;
      if (prog_r[3:0] == 4'h0)
         bcs_nxt = 1'b0; // see RL20
      if (stop_req)
         bcs_nxt = 1'b0; // see RL8
      // acq_r is the hidden manual store, untouched in auto, see RL14
      irq_nxt = flag_nxt & ie_nxt & auto_nxt; // see RL24 RL2 RL3
      // range zero forces the loop off whatever the power bit says, see RL20
      en_nxt = on_nxt & (prog_nxt[3:0] != 4'h0) & ~stop_req;
      fb_nxt = eff_mult(prog_nxt); // see RL18
   end

   // source switch: wait on both clocks, hold output meanwhile
   always_comb begin
      sw_nxt = sw_r;
      xcnt_nxt = xcnt_r;
      vcnt_nxt = vcnt_r;
      sel_nxt = sel_r;
      hold_nxt = hold_r;
      case (sw_r)
         PLLCG_SW_IDLE: begin
            if (bcs_r != sel_r) begin
               sw_nxt = PLLCG_SW_XTAL;
               hold_nxt = 1'b1; // see RL7
               xcnt_nxt = 2'h0;
               vcnt_nxt = 2'h0;
            end
         end
         PLLCG_SW_XTAL: begin
            if (xtal_edge)
               xcnt_nxt = xcnt_r + 2'h1;
            if (xtal_edge && (xcnt_r == `PLLCG_SW_XCYC - 2'h1))
               sw_nxt = PLLCG_SW_VCO;
         end
         PLLCG_SW_VCO: begin
            // a stopped VCO never completes; source falls back to crystal once source select clears
            if (vco_edge)
               vcnt_nxt = vcnt_r + 2'h1;
            if ((vco_edge && (vcnt_r == `PLLCG_SW_VCYC - 2'h1)) || !bcs_r) begin
               sw_nxt = PLLCG_SW_IDLE;
               sel_nxt = bcs_r;
               hold_nxt = 1'b0;
            end
         end
         default: sw_nxt = PLLCG_SW_IDLE;
      endcase
   end

   // no wait input: all state keeps running through wait mode, see RL22
   always_ff @(posedge clk) begin
      if (rst) begin
         ie_r <= 1'b0;
         flag_r <= 1'b0;
         on_r <= 1'b1; // see RL5
         bcs_r <= 1'b0; // see RL8
         auto_r <= 1'b0; // see RL11
         acq_r <= 1'b0; // see RL13
         lock_r <= 1'b0;
         lock_q_r <= 1'b0;
         bwtest_r <= 4'h0;
         prog_r <= `PLLCG_PROG_RST; // see RL18 RL20
         chk_r <= 1'b0;
         irq_r <= 1'b0;
         en_r <= 1'b1; // see RL5
         fb_r <= eff_mult(`PLLCG_PROG_RST); // see RL18
      end else begin
         ie_r <= ie_nxt;
         flag_r <= flag_nxt;
         on_r <= on_nxt;
         bcs_r <= bcs_nxt;
         auto_r <= auto_nxt;
         acq_r <= acq_nxt;
         lock_r <= lock_nxt;
         lock_q_r <= lock_q_nxt;
         bwtest_r <= bwtest_nxt;
         prog_r <= prog_nxt;
         chk_r <= chk_nxt;
         irq_r <= irq_nxt;
         en_r <= en_nxt;
         fb_r <= fb_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sw_r <= PLLCG_SW_IDLE;
         xcnt_r <= 2'h0;
         vcnt_r <= 2'h0;
         sel_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         sw_r <= sw_nxt;
         xcnt_r <= xcnt_nxt;
         vcnt_r <= vcnt_nxt;
         sel_r <= sel_nxt;
         hold_r <= hold_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         awh_r <= 1'b0;
         wh_r <= 1'b0;
         awa_r <= 4'h0;
         wd_r <= 8'h00;
         wen_r <= 1'b0;
         bv_r <= 1'b0;
         bresp_r <= 2'h0;
         rv_r <= 1'b0;
         rd_r <= 8'h00;
         rresp_r <= 2'h0;
         awrdy_r <= 1'b1;
         wrdy_r <= 1'b1;
         ardy_r <= 1'b1;
      end else begin
         awh_r <= awh_nxt;
         wh_r <= wh_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         wen_r <= wen_nxt;
         bv_r <= bv_nxt;
         bresp_r <= bresp_nxt;
         rv_r <= rv_nxt;
         rd_r <= rd_nxt;
         rresp_r <= rresp_nxt;
         awrdy_r <= awrdy_nxt;
         wrdy_r <= wrdy_nxt;
         ardy_r <= ardy_nxt;
      end
   end

   always_comb begin
      axi_rsp.awready = awrdy_r;
      axi_rsp.wready = wrdy_r;
      axi_rsp.bvalid = bv_r;
      axi_rsp.bresp = bresp_r;
      axi_rsp.arready = ardy_r;
      axi_rsp.rvalid = rv_r;
      axi_rsp.rdata = {24'h000000, rd_r};
      axi_rsp.rresp = rresp_r;
   end

   assign loop_enable = en_r;
   assign vco_selected = sel_r;
   assign base_clock_hold = hold_r;
   assign feedback_div = fb_r;
   assign range_mult = prog_r[3:0];
   assign manual_capture_phase_n = acq_r;
   assign loss_check_start = chk_r;
   assign loop_irq = irq_r;
endmodule // pllcg_top

// *** pllcg_monitor.sv ***
/* port checker for pllcg_top.
 assumes the bind below reaches every pllcg_top instance. */
`timescale 1ns/10ps
module pllcg_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire pllcg_pkg::pllcg_axi_req_t axi_req,
   input wire pllcg_pkg::pllcg_axi_rsp_t axi_rsp,
   input wire logic stop_req,
   input wire logic xtal_edge,
   input wire logic vco_edge,
   input wire logic loop_enable,
   input wire logic vco_selected,
   input wire logic base_clock_hold,
   input wire logic [3:0] feedback_div,
   input wire logic [3:0] range_mult,
   input wire logic loop_irq
);
   import pllcg_pkg::*;
   logic [3:0] a_r, a_nxt, n_r, n_nxt;
   // n_r counts cycles giving both edges during a switch
   always_comb begin
      a_nxt = (axi_req.arvalid && axi_rsp.arready) ? axi_req.araddr : a_r;
      n_nxt = n_r;
      if (!base_clock_hold) n_nxt = 4'h0;
      else if (xtal_edge && vco_edge && n_r != 4'hf) n_nxt = n_r + 4'h1;
   end
   always_ff @(posedge clk) begin
      a_r <= rst ? 4'hf : a_nxt;
      n_r <= rst ? 4'h0 : n_nxt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_fb_nonzero: assert property (feedback_div != 4'h0)
      else $error("feedback divider shows zero");
   chk_reset_vals: assert property (disable iff (1'b0) rst |=>
      !vco_selected && !base_clock_hold && !loop_irq && (loop_enable || stop_req)
      && feedback_div == 4'h6 && range_mult == 4'h6) else $error("bad reset values");
   chk_range_off: assert property (range_mult == 4'h0 |-> !loop_enable)
      else $error("loop on with zero range");
   chk_stop_off: assert property (stop_req |=> !loop_enable)
      else $error("loop on during stop");
   chk_prog_locked: assert property (loop_enable |=> $stable(range_mult)
      && $stable(feedback_div)) else $error("multiplier changed while loop on");
   chk_switch_held: assert property ($changed(vco_selected) |-> $past(base_clock_hold))
      else $error("source changed without hold");
   chk_switch_bound: assert property (n_r < 4'h8)
      else $error("source switch too long");
   chk_unused_ones: assert property (axi_rsp.rvalid && a_r == 4'h0
      |-> axi_rsp.rdata[3:0] == 4'hf) else $error("unused control bits not one");
   cover property ($rose(vco_selected));
   cover property ($rose(loop_irq));
   cover property (range_mult == 4'h0 && axi_rsp.bvalid);
endmodule // pllcg_monitor
bind pllcg_top pllcg_monitor u_mon (.clk(clk), .rst(rst), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .stop_req(stop_req), .xtal_edge(xtal_edge), .vco_edge(vco_edge),
   .loop_enable(loop_enable), .vco_selected(vco_selected), .base_clock_hold(base_clock_hold),
   .feedback_div(feedback_div), .range_mult(range_mult), .loop_irq(loop_irq));

// *** test_pll_clock_generator_control.sv ***
/* self-checking bench for pllcg_top: axi-lite reads checked against notes.
 assumes pllcg_pkg and pllcg_monitor are compiled first. */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module test_pll_clock_generator_control;
   import pllcg_pkg::*;
   logic clk = 0;
   logic rst = 1;
   pllcg_axi_req_t req = '0;
   pllcg_axi_rsp_t rsp;
   logic stop_req = 0, lock_in = 0, trk = 0, lost = 0, xe = 0, ve = 0;
   logic en, vsel, hold, cap, lcs, irq;
   logic [3:0] fb, rm;
   logic [7:0] lf = 8'h56;
   logic [65:0] q[$];
   logic [65:0] e;
   logic [1:0] bq[$];
   logic [1:0] eb;
   int err_count = 0;
   int n_checks = 0;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   always #5 clk = ~clk;
   // random clock edge pulses stretch source switches unevenly
   always @(posedge clk) begin
      lf <= lfsr(lf);
      xe <= lf[0];
      ve <= lf[4];
   end
   task give_verdict;
      if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task tmo(input int n);
      if (n >= 300) begin
         err_count++;
         give_verdict;
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      int k;
      bq.push_back((a == 4'h0 || a == 4'h4 || a == 4'h8) ? 2'h0 : 2'h2);
      req.awaddr <= a;
      req.awvalid <= 1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      req.wvalid <= 1;
      req.bready <= 1;
      for (k = 0; k < 300; k++) begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 0;
         if (rsp.wready) req.wvalid <= 0;
         if (rsp.bvalid) break;
      end
      tmo(k);
   endtask
   // note: resp, mask, expected word
   task rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m, input logic [1:0] r);
      int k;
      q.push_back({r, 24'hffffff, m, 24'h0, x});
      req.araddr <= a;
      req.arvalid <= 1;
      req.rready <= 1;
      for (k = 0; k < 300; k++) begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 0;
         if (rsp.rvalid) break;
      end
      tmo(k);
   endtask
   task wt(input logic v);
      int k;
      for (k = 0; k < 300 && vsel !== v; k++) @(posedge clk);
      tmo(k);
   endtask
   task rst_chk;
      rst <= 1;
      repeat (5) @(posedge clk);
      rst <= 0;
      rd(4'h0, 8'h2f, 8'hff, 2'h0);
      rd(4'h4, 8'h00, 8'hf0, 2'h0);
      rd(4'h8, 8'h66, 8'hff, 2'h0);
      rd(4'h2, 8'h00, 8'hff, 2'h2);
   endtask
   always @(posedge clk) begin
      if (rsp.rvalid && req.rready && q.size() > 0) begin
         e = q.pop_front();
         `CHK({rsp.rresp, rsp.rdata & e[63:32]}, {e[65:64], e[31:0]})
      end
      if (rsp.bvalid && req.bready && bq.size() > 0) begin
         eb = bq.pop_front();
         `CHK(rsp.bresp, eb)
      end
   end
   initial begin
      rst_chk;
      wr(4'h0, 8'ha0);
      rd(4'h0, 8'h2f, 8'hff, 2'h0);
      lock_in <= 1;
      repeat (6) @(posedge clk);
      `CHK(irq, 1'b0)
      rd(4'h0, 8'h2f, 8'hff, 2'h0);
      lock_in <= 0;
      wr(4'h8, 8'h3a);
      rd(4'h8, 8'h66, 8'hff, 2'h0);
      wr(4'h4, 8'h20);
      rd(4'h4, 8'h20, 8'hf0, 2'h0);
      wr(4'h4, 8'ha0);
      rd(4'h4, 8'h80, 8'hf0, 2'h0);
      wr(4'h4, 8'h80);
      wr(4'h0, 8'ha0);
      trk <= 1;
      lock_in <= 1;
      repeat (6) @(posedge clk);
      `CHK(irq, 1'b1)
      rd(4'h0, 8'hef, 8'hff, 2'h0);
      rd(4'h0, 8'haf, 8'hff, 2'h0);
      `CHK(irq, 1'b0)
      rd(4'h4, 8'he0, 8'hf0, 2'h0);
      lock_in <= 0;
      repeat (6) @(posedge clk);
      `CHK(irq, 1'b1)
      wr(4'h4, 8'h00);
      `CHK(irq, 1'b0)
      rd(4'h0, 8'h2f, 8'hff, 2'h0);
      `CHK(cap, 1'b1)
      rd(4'h4, 8'h20, 8'hf0, 2'h0);
      trk <= 0;
      wr(4'h0, 8'h00);
      wr(4'h8, 8'h05);
      rd(4'h8, 8'h05, 8'hff, 2'h0);
      `CHK({fb, rm}, 8'h15)
      wr(4'h8, 8'h70);
      wr(4'h0, 8'h20);
      `CHK(en, 1'b0)
      wr(4'h0, 8'h30);
      rd(4'h0, 8'h2f, 8'hff, 2'h0);
      wr(4'h0, 8'h00);
      wr(4'h8, 8'h75);
      `CHK({fb, rm}, 8'h75)
      wr(4'h0, 8'h30);
      rd(4'h0, 8'h2f, 8'hff, 2'h0);
      `CHK(en, 1'b1)
      wr(4'h0, 8'h30);
      rd(4'h0, 8'h3f, 8'hff, 2'h0);
      `CHK(hold, 1'b1)
      wt(1'b1);
      wr(4'h0, 8'h10);
      rd(4'h0, 8'h3f, 8'hff, 2'h0);
      rd(4'hc, 8'h01, 8'h03, 2'h0);
      wr(4'hc, 8'h00);
      lost <= 1;
      wr(4'h4, 8'h10);
      repeat (28) @(posedge clk);
      `CHK(lcs, 1'b1)
      rd(4'h4, 8'h10, 8'h10, 2'h0);
      stop_req <= 1;
      repeat (2) @(posedge clk);
      `CHK(en, 1'b0)
      stop_req <= 0;
      rd(4'h0, 8'h2f, 8'hff, 2'h0);
      rd(4'h4, 8'h00, 8'h10, 2'h0);
      wt(1'b0);
      rst_chk;
      give_verdict;
   end
   pllcg_top DUT (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .stop_req(stop_req),
      .lock_in(lock_in), .tracking_in(trk), .xtal_lost_in(lost), .xtal_edge(xe), .vco_edge(ve),
      .loop_enable(en), .vco_selected(vsel), .base_clock_hold(hold), .feedback_div(fb),
      .range_mult(rm), .manual_capture_phase_n(cap), .loss_check_start(lcs), .loop_irq(irq));
endmodule // test_pll_clock_generator_control
